// ==== logic/vcs_pkg.sv ====
package vcs_pkg;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [7:0]  OFF_CAP  = 8'ha4;
    localparam logic [7:0]  OFF_TSTA = 8'ha8;
    localparam logic [7:0]  OFF_TSTB = 8'hac;
    localparam logic [7:0]  OFF_TMR  = 8'hb0;
    localparam logic [7:0]  OFF_MODE = 8'hb4;

    // ========================================
    // Capability header constants
    localparam logic [7:0]  CAP_ID   = 8'h09;
    localparam logic [7:0]  CAP_NEXT = 8'hc4;
    localparam logic [15:0] CAP_LEN  = 16'h000c;

    // ========================================
    // Reset values
    localparam logic [31:0] TSTA_RST = 32'h04001060;
    localparam logic [31:0] TSTB_RST = 32'h04000800;
    localparam logic [31:0] TMR_RST  = 32'h80000000;
    localparam logic [15:0] MODE_RST = 16'h0002;

    // ========================================
    // Write masks: software, serial loader, EEPROM loader
    localparam logic [31:0] TMR_SW_MSK  = 32'h7fff1fff;
    localparam logic [31:0] TMR_SMB_MSK = 32'h7fffffff;
    localparam logic [31:0] TMR_EE_MSK  = 32'hffffffff;
    localparam logic [15:0] MODE_SW_MSK = 16'h3f7f;
    localparam logic [15:0] MODE_LD_MSK = 16'hff7f;

    // ========================================
    // Timer word fields
    localparam int RPL_LSB = 0;
    localparam int RPL_W   = 12;
    localparam int RPL_EN  = 12;
    localparam int PM_DIS  = 13;
    localparam int MSI_DIS = 14;
    localparam int AER_DIS = 15;
    localparam int ACK_LSB = 16;
    localparam int ACK_W   = 14;
    localparam int ACK_EN  = 30;
    localparam int VGA_EN  = 31;

    // ========================================
    // Operation mode fields
    localparam int MD_SF   = 0;
    localparam int MD_CT   = 1;
    localparam int MD_ARB  = 3;
    localparam int MD_CRED = 4;
    localparam int MD_OEGR = 5;
    localparam int MD_OTAG = 6;
    localparam int MD_PMP  = 8;
    localparam int PMP_W   = 6;
    localparam int MD_RXP  = 14;
    localparam int MD_CPAR = 15;

    // ========================================
    // Credits released per flow-control update
    localparam logic [1:0]  CRED_ONE = 2'h1;
    localparam logic [1:0]  CRED_TWO = 2'h2;

endpackage

// ==== logic/vcs_rr_arb.sv ====
`timescale 1ns/1ps

module vcs_rr_arb #(
    parameter int N  = 4,
    parameter int IW = $clog2(N)
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          ce,
    input  wire logic          hold,
    input  wire logic [N-1:0]  req,
    input  wire logic [N-1:0]  credit_ok,
    output logic      [IW-1:0] gidx_r,
    output logic               gvld_r
);

    logic [IW-1:0] gidx_nxt;
    logic          found;
    int            j;

    // ========================================
    // Next owner search
    // Rotates from the port after the owner; the owner itself is tried last
    always_comb begin
        gidx_nxt = gidx_r;
        found    = 1'b0;
        j        = 0;
        for (int i = 1; i <= N; i++) begin
            j = (int'(gidx_r) + i) % N;
            if (!found && req[j] && credit_ok[j]) begin
                gidx_nxt = IW'(j);
                found    = 1'b1;
            end
        end
        // Sticky owner ignores its own credit shortage
        if (hold && req[gidx_r]) begin
            gidx_nxt = gidx_r;
        end
    end

    // ========================================
    // Owner and grant flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gidx_r <= '0;
            gvld_r <= 1'b0;
        end else if (ce) begin
            gidx_r <= gidx_nxt;
            gvld_r <= req[gidx_nxt] & credit_ok[gidx_nxt];
        end
    end

endmodule

// ==== logic/vcs_ctrl_regs.sv ====
// Function
// - capability ID byte reads fixed 09h
// - next pointer byte reads fixed C4h
// - structure length reads fixed 000Ch
// - 12-bit user replay timeout, resets zero
// - enable bit selects user replay timeout
// - defaults loadable by serial bus or EEPROM
// - 14-bit user ACK latency, resets zero
// - enable bit selects user ACK latency
// - VGA enable read-only, reset one, EEPROM only
// - mode bit 0 selects store-and-forward
// - cut-through start point at or ahead of midpoint
// - hold mode keeps arbiter on pending owner
// - otherwise arbiter moves to port with credit
// - credit release one or two per update
// - ordering across egress ports when set
// - ordering across completion tags when set
`timescale 1ns/1ps

module vcs_ctrl_regs #(
    parameter int         NPORT   = 4,
    parameter int         PW      = $clog2(NPORT),
    parameter int         LENW    = 8,
    parameter logic [5:0] PMP_RST = 6'h00
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic [7:0]       addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic      [31:0]      rdata,
    input  wire logic             ld_wr,
    input  wire logic             ld_eeprom,
    input  wire logic [7:0]       ld_addr,
    input  wire logic [31:0]      ld_data,
    input  wire logic [11:0]      dflt_replay,
    input  wire logic [13:0]      dflt_ack,
    output logic      [11:0]      replay_tmo,
    output logic      [13:0]      ack_lat,
    output logic                  pm_cap_dis,
    output logic                  msi_cap_dis,
    output logic                  aer_cap_dis,
    output logic                  vga_cap_en,
    output logic                  store_fwd,
    output logic      [1:0]       cred_per_upd,
    output logic                  ord_egress,
    output logic                  ord_cpl_tag,
    output logic      [5:0]       pm_param,
    output logic                  rx_pol_dis,
    output logic                  cpar_dis,
    input  wire logic [LENW-1:0]  pkt_cycles,
    input  wire logic             slow_to_fast,
    output logic      [LENW-1:0]  ct_start,
    input  wire logic [NPORT-1:0] req,
    input  wire logic [NPORT-1:0] credit_ok,
    output logic      [PW-1:0]    grant_idx,
    output logic                  grant_vld
);

    // ========================================
    // Storage
    logic [31:0]     rdata_r;
    logic [31:0]     tsta_r;
    logic [31:0]     tstb_r;
    logic [31:0]     tmr_r;
    logic [15:0]     mode_r;
    logic [11:0]     replay_r;
    logic [13:0]     ack_r;
    logic [1:0]      cred_r;
    logic [LENW-1:0] ct_start_r;
    logic [LENW-1:0] ct_start_nxt;
    logic [LENW-1:0] half;
    logic [LENW-1:0] thr;
    logic            sw_tmr;
    logic            sw_mode;
    logic            ld_tmr;
    logic            ld_mode;
    logic [31:0]     ld_tmr_msk;

    // ========================================
    // Helpers
    // Word match ignores the two byte-lane bits
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // Replace only the bits a writer is allowed to touch
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] msk);
        merge = (old & ~msk) | (nw & msk);
    endfunction

    // ========================================
    // Write decode
    // A software write beats a loader write in the same cycle
    assign sw_tmr     = wr && hit(addr, vcs_pkg::OFF_TMR);
    assign sw_mode    = wr && hit(addr, vcs_pkg::OFF_MODE);
    assign ld_tmr     = ld_wr && hit(ld_addr, vcs_pkg::OFF_TMR);
    assign ld_mode    = ld_wr && hit(ld_addr, vcs_pkg::OFF_MODE);
    // Only the EEPROM path reaches the VGA enable
    assign ld_tmr_msk = ld_eeprom ? vcs_pkg::TMR_EE_MSK : vcs_pkg::TMR_SMB_MSK;

    // ========================================
    // Test-only words, fully writable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tsta_r <= vcs_pkg::TSTA_RST;
            tstb_r <= vcs_pkg::TSTB_RST;
        end else if (ce) begin
            if (wr && hit(addr, vcs_pkg::OFF_TSTA)) begin
                tsta_r <= wdata;
            end else if (ld_wr && hit(ld_addr, vcs_pkg::OFF_TSTA)) begin
                tsta_r <= ld_data;
            end
            if (wr && hit(addr, vcs_pkg::OFF_TSTB)) begin
                tstb_r <= wdata;
            end else if (ld_wr && hit(ld_addr, vcs_pkg::OFF_TSTB)) begin
                tstb_r <= ld_data;
            end
        end
    end

    // ========================================
    // Timer control word
    // Software reaches user values and enables; disables and VGA are loader only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmr_r <= vcs_pkg::TMR_RST;
        end else if (ce) begin
            if (sw_tmr) begin
                tmr_r <= merge(tmr_r, wdata, vcs_pkg::TMR_SW_MSK);
            end else if (ld_tmr) begin
                tmr_r <= merge(tmr_r, ld_data, ld_tmr_msk);
            end
        end
    end

    // ========================================
    // Operation mode word
    // Reserved bit 7 never stores; bits 14 and 15 are loader only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= vcs_pkg::MODE_RST | {2'h0, PMP_RST, 8'h00};
        end else if (ce) begin
            if (sw_mode) begin
                mode_r <= 16'(merge({16'h0, mode_r}, wdata, {16'h0, vcs_pkg::MODE_SW_MSK}));
            end else if (ld_mode) begin
                mode_r <= 16'(merge({16'h0, mode_r}, ld_data, {16'h0, vcs_pkg::MODE_LD_MSK}));
            end
        end
    end

    // ========================================
    // Read port, data valid the cycle after the strobe
    // Unmapped words read zero; header is constant
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h0;
        end else if (ce) begin
            if (!rd) begin
                rdata_r <= 32'h0;
            end else if (hit(addr, vcs_pkg::OFF_CAP)) begin
                rdata_r <= {vcs_pkg::CAP_LEN, vcs_pkg::CAP_NEXT, vcs_pkg::CAP_ID};
            end else if (hit(addr, vcs_pkg::OFF_TSTA)) begin
                rdata_r <= tsta_r;
            end else if (hit(addr, vcs_pkg::OFF_TSTB)) begin
                rdata_r <= tstb_r;
            end else if (hit(addr, vcs_pkg::OFF_TMR)) begin
                rdata_r <= tmr_r;
            end else if (hit(addr, vcs_pkg::OFF_MODE)) begin
                rdata_r <= {16'h0, mode_r};
            end else begin
                rdata_r <= 32'h0;
            end
        end
    end

    // ========================================
    // Effective timer values
    // Internal defaults track live while the user enable is clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            replay_r <= 12'h0;
            ack_r    <= 14'h0;
        end else if (ce) begin
            if (tmr_r[vcs_pkg::RPL_EN]) begin
                replay_r <= tmr_r[vcs_pkg::RPL_LSB +: vcs_pkg::RPL_W];
            end else begin
                replay_r <= dflt_replay;
            end
            if (tmr_r[vcs_pkg::ACK_EN]) begin
                ack_r <= tmr_r[vcs_pkg::ACK_LSB +: vcs_pkg::ACK_W];
            end else begin
                ack_r <= dflt_ack;
            end
        end
    end

    // ========================================
    // Credit release rate
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cred_r <= vcs_pkg::CRED_TWO;
        end else if (ce) begin
            cred_r <= mode_r[vcs_pkg::MD_CRED] ? vcs_pkg::CRED_ONE : vcs_pkg::CRED_TWO;
        end
    end

    // ========================================
    // Forwarding start cycle for the packet on offer
    // Short packets clamp at zero rather than wrap
    always_comb begin
        half = pkt_cycles >> 1;
        thr  = LENW'(mode_r[vcs_pkg::MD_CT +: 2]);
        if (mode_r[vcs_pkg::MD_SF]) begin
            ct_start_nxt = pkt_cycles;
        end else if (!slow_to_fast) begin
            ct_start_nxt = '0;
        end else if (half > thr) begin
            ct_start_nxt = half - thr;
        end else begin
            ct_start_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ct_start_r <= '0;
        end else if (ce) begin
            ct_start_r <= ct_start_nxt;
        end
    end

    // ========================================
    // Port arbiter
    vcs_rr_arb #(
        .N  (NPORT),
        .IW (PW)
    ) u_arb (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .hold      (mode_r[vcs_pkg::MD_ARB]),
        .req       (req),
        .credit_ok (credit_ok),
        .gidx_r    (grant_idx),
        .gvld_r    (grant_vld)
    );

    // ========================================
    // Outputs, all taken from flops
    assign rdata        = rdata_r;
    assign replay_tmo   = replay_r;
    assign ack_lat      = ack_r;
    assign pm_cap_dis   = tmr_r[vcs_pkg::PM_DIS];
    assign msi_cap_dis  = tmr_r[vcs_pkg::MSI_DIS];
    assign aer_cap_dis  = tmr_r[vcs_pkg::AER_DIS];
    assign vga_cap_en   = tmr_r[vcs_pkg::VGA_EN];
    assign store_fwd    = mode_r[vcs_pkg::MD_SF];
    assign cred_per_upd = cred_r;
    assign ord_egress   = mode_r[vcs_pkg::MD_OEGR];
    assign ord_cpl_tag  = mode_r[vcs_pkg::MD_OTAG];
    assign pm_param     = mode_r[vcs_pkg::MD_PMP +: vcs_pkg::PMP_W];
    assign rx_pol_dis   = mode_r[vcs_pkg::MD_RXP];
    assign cpar_dis     = mode_r[vcs_pkg::MD_CPAR];
    assign ct_start     = ct_start_r;

endmodule

// ==== dv/vcs_ctrl_regs_checker.sv ====
`timescale 1ns/1ps

module vcs_ctrl_regs_checker #(
    parameter int NPORT = 4,
    parameter int PW    = 2
) (
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             ce,
    input wire logic [7:0]       addr,
    input wire logic [31:0]      wdata,
    input wire logic             wr,
    input wire logic             rd,
    input wire logic [31:0]      rdata,
    input wire logic             ld_wr,
    input wire logic             ld_eeprom,
    input wire logic [11:0]      dflt_replay,
    input wire logic [11:0]      replay_tmo,
    input wire logic             vga_cap_en,
    input wire logic             store_fwd,
    input wire logic [1:0]       cred_per_upd,
    input wire logic [NPORT-1:0] req,
    input wire logic [NPORT-1:0] credit_ok,
    input wire logic [PW-1:0]    grant_idx,
    input wire logic             grant_vld
);
    // ========================================
    // Helpers
    logic [NPORT-1:0] ok_d;

    // Qualified requests, frozen like the design when ce is low
    always_ff @(posedge clk) begin
        if (ce) begin
            ok_d <= req & credit_ok;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ========================================
    // Assertions
    sequence s_quiet;
        ce && !wr && !ld_wr;
    endsequence
    sequence s_mode_wr;
        ce && wr && addr[7:2] == 6'h2d;
    endsequence

    a_cap_const: assert property (ce && rd && addr[7:2] == 6'h29 |=> rdata == 32'h000cc409)
        else $error("capability header word wrong");
    a_rdata_idle: assert property (ce && !rd |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    // The loader edge that stores bit 31 is the one just before the change is seen
    a_vga_eeprom: assert property ($changed(vga_cap_en) |-> $past(ld_wr && ld_eeprom))
        else $error("vga enable changed without EEPROM load");
    a_sf_select: assert property (s_mode_wr ##1 s_quiet |=> store_fwd == $past(wdata[0], 2))
        else $error("store forward select wrong");
    a_cred_rate: assert property (s_mode_wr ##1 s_quiet |=> cred_per_upd == ($past(wdata[4], 2) ? 2'h1 : 2'h2))
        else $error("credit release rate wrong");
    a_rpl_user: assert property (ce && wr && addr[7:2] == 6'h2c && wdata[12] ##1 s_quiet
        |=> replay_tmo == $past(wdata[11:0], 2))
        else $error("user replay timeout not used");
    a_rpl_dflt: assert property (ce && wr && addr[7:2] == 6'h2c && !wdata[12] ##1 s_quiet
        |=> replay_tmo == $past(dflt_replay))
        else $error("default replay timeout not used");
    a_grant_vld: assert property ($past(ce) && $past(nrst) |-> grant_vld == ok_d[grant_idx])
        else $error("grant valid does not match owner");
endmodule

bind vcs_ctrl_regs vcs_ctrl_regs_checker #(.NPORT(NPORT), .PW(PW)) u_chk (
    .clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ld_wr(ld_wr), .ld_eeprom(ld_eeprom), .dflt_replay(dflt_replay), .replay_tmo(replay_tmo),
    .vga_cap_en(vga_cap_en), .store_fwd(store_fwd), .cred_per_upd(cred_per_upd), .req(req),
    .credit_ok(credit_ok), .grant_idx(grant_idx), .grant_vld(grant_vld));

// ==== dv/vcs_ctrl_regs_bench.sv ====
`timescale 1ns/1ps

module vcs_ctrl_regs_bench;
    // ========================================
    // Stimulus and observed signals
    logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        ld_wr = 1'b0, ld_eeprom = 1'b0, slow_to_fast = 1'b0;
    logic [7:0]  addr = 8'h0, ld_addr = 8'h0, pkt_cycles = 8'h0;
    logic [31:0] wdata = 32'h0, ld_data = 32'h0, rdata;
    logic [11:0] dflt_replay = 12'h123, replay_tmo;
    logic [13:0] dflt_ack = 14'h0456, ack_lat;
    logic [3:0]  req = 4'h0, credit_ok = 4'h0;
    logic [7:0]  ct_start;
    logic [5:0]  pm_param;
    logic [1:0]  cred_per_upd, grant_idx;
    logic        pm_cap_dis, msi_cap_dis, aer_cap_dis, vga_cap_en, store_fwd;
    logic        ord_egress, ord_cpl_tag, rx_pol_dis, cpar_dis, grant_vld;
    logic [4:0]  mflags;
    logic [3:0]  tflags;
    int          n_errors = 0, total_checks = 0, cycles = 0;

    // Flags packed so one compare covers several flags of a word
    assign mflags = {store_fwd, cred_per_upd, ord_egress, ord_cpl_tag};
    assign tflags = {pm_cap_dis, msi_cap_dis, aer_cap_dis, vga_cap_en};

    always #20 clk = ~clk;

    vcs_ctrl_regs u_vcs_ctrl_regs (
        .clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ld_wr(ld_wr), .ld_eeprom(ld_eeprom), .ld_addr(ld_addr), .ld_data(ld_data),
        .dflt_replay(dflt_replay), .dflt_ack(dflt_ack), .replay_tmo(replay_tmo), .ack_lat(ack_lat),
        .pm_cap_dis(pm_cap_dis), .msi_cap_dis(msi_cap_dis), .aer_cap_dis(aer_cap_dis),
        .vga_cap_en(vga_cap_en), .store_fwd(store_fwd), .cred_per_upd(cred_per_upd),
        .ord_egress(ord_egress), .ord_cpl_tag(ord_cpl_tag), .pm_param(pm_param),
        .rx_pol_dis(rx_pol_dis), .cpar_dis(cpar_dis), .pkt_cycles(pkt_cycles),
        .slow_to_fast(slow_to_fast), .ct_start(ct_start), .req(req), .credit_ok(credit_ok),
        .grant_idx(grant_idx), .grant_vld(grant_vld));

    // ========================================
    // Tasks
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One bus cycle; always returns just after the sampling edge
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        #1;
    endtask

    task automatic idle();
        bus(1'b0, 1'b0, 8'h0, 32'h0);
    endtask

    // Read data stands from the cycle after the strobe until the next cycle with ce high
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, 1'b1, a, 32'h0);
        chk(rdata, e);
    endtask

    task automatic tmr(input logic [31:0] d, input logic [31:0] e, input logic [11:0] rp, input logic [13:0] ak);
        bus(1'b1, 1'b0, vcs_pkg::OFF_TMR, d);
        rdc(vcs_pkg::OFF_TMR, e);
        chk(32'(replay_tmo), 32'(rp));
        chk(32'(ack_lat), 32'(ak));
    endtask

    task automatic md(input logic [31:0] d, input logic [31:0] e, input logic [4:0] f);
        bus(1'b1, 1'b0, vcs_pkg::OFF_MODE, d);
        rdc(vcs_pkg::OFF_MODE, e);
        chk(32'(mflags), 32'(f));
    endtask

    task automatic ctc(input logic [31:0] m, input logic [31:0] e);
        bus(1'b1, 1'b0, vcs_pkg::OFF_MODE, m);
        repeat (3) idle();
        chk(32'(ct_start), e);
    endtask

    // Mode write first, then steady requests for a few arbitration rounds
    task automatic arb(input logic [31:0] m, input logic [3:0] rq, input logic [3:0] cr, input logic [2:0] e);
        bus(1'b1, 1'b0, vcs_pkg::OFF_MODE, m);
        req <= rq;
        credit_ok <= cr;
        repeat (3) idle();
        chk(32'({grant_vld, grant_idx}), 32'(e));
    endtask

    task automatic ld(input logic ee, input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b0;
        rd <= 1'b0;
        ld_wr <= 1'b1;
        ld_eeprom <= ee;
        ld_addr <= a;
        ld_data <= d;
        @(posedge clk);
        #1;
        ld_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // ========================================
    // Hang guard, far above the expected hundred or so cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        #1;
        idle();
        chk(32'(replay_tmo), 32'h123);
        chk(32'(ack_lat), 32'h456);
        chk(32'(tflags), 32'h1);
        chk(32'(mflags), 32'h08);
        rdc(vcs_pkg::OFF_CAP, 32'h000cc409);
        rdc(vcs_pkg::OFF_TSTA, 32'h04001060);
        rdc(vcs_pkg::OFF_TSTB, 32'h04000800);
        rdc(vcs_pkg::OFF_TMR, 32'h80000000);
        rdc(vcs_pkg::OFF_MODE, 32'h00000002);
        bus(1'b1, 1'b0, vcs_pkg::OFF_CAP, 32'hffffffff);
        rdc(vcs_pkg::OFF_CAP, 32'h000cc409);
        bus(1'b1, 1'b0, vcs_pkg::OFF_TSTB, 32'h5a5a0ff0);
        rdc(vcs_pkg::OFF_TSTB, 32'h5a5a0ff0);
        // Clock enable low: the write is dropped and read data holds
        ce <= 1'b0;
        bus(1'b1, 1'b0, vcs_pkg::OFF_TSTA, 32'h0badf00d);
        chk(rdata, 32'h5a5a0ff0);
        ce <= 1'b1;
        rdc(vcs_pkg::OFF_TSTA, 32'h04001060);
        rdc(8'hc0, 32'h0);
        tmr(32'h40001005, 32'hc0001005, 12'h005, 14'h0000);
        tmr(32'hffffffff, 32'hffff1fff, 12'hfff, 14'h3fff);
        tmr(32'h3fff0fff, 32'hbfff0fff, 12'h123, 14'h0456);
        md(32'h007f, 32'h0000007f, 5'h17);
        md(32'hffff, 32'h00003f7f, 5'h17);
        md(32'h0000, 32'h00000000, 5'h08);
        pkt_cycles <= 8'd20;
        slow_to_fast <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            ctc(32'(c << 1), 32'(10 - c));
        end
        pkt_cycles <= 8'd4;
        ctc(32'h6, 32'h0);
        pkt_cycles <= 8'd20;
        slow_to_fast <= 1'b0;
        ctc(32'h2, 32'h0);
        ctc(32'h1, 32'd20);
        arb(32'h0, 4'h2, 4'h2, 3'h5);
        arb(32'h0, 4'h3, 4'h1, 3'h4);
        arb(32'h8, 4'h3, 4'h1, 3'h4);
        arb(32'h8, 4'h3, 4'h2, 3'h0);
        arb(32'h0, 4'h3, 4'h2, 3'h5);
        ld(1'b1, vcs_pkg::OFF_TMR, 32'h0);
        rdc(vcs_pkg::OFF_TMR, 32'h0);
        chk(32'(tflags), 32'h0);
        ld(1'b0, vcs_pkg::OFF_TMR, 32'hffffffff);
        rdc(vcs_pkg::OFF_TMR, 32'h7fffffff);
        chk(32'(tflags), 32'he);
        bus(1'b1, 1'b0, vcs_pkg::OFF_TMR, 32'h0);
        rdc(vcs_pkg::OFF_TMR, 32'h0000e000);
        ld(1'b0, vcs_pkg::OFF_MODE, 32'hffff);
        rdc(vcs_pkg::OFF_MODE, 32'h0000ff7f);
        chk(32'({rx_pol_dis, cpar_dis, pm_param}), 32'hff);
        nrst <= 1'b0;
        idle();
        nrst <= 1'b1;
        idle();
        rdc(vcs_pkg::OFF_TMR, 32'h80000000);
        chk(32'(tflags), 32'h1);
        wrap_up();
    end
endmodule
